//--- src/tpc_cfg.svh
// touch probe capture: object indices, control and status bit positions
// assumes inclusion by the package and the capture module
`ifndef TPC_CFG_SVH
`define TPC_CFG_SVH

`define TPC_IDX_CTRL      16'h60b8
`define TPC_IDX_STAT      16'h60b9
`define TPC_IDX_P1_RISE   16'h60ba
`define TPC_IDX_P1_FALL   16'h60bb
`define TPC_IDX_P2_RISE   16'h60bc
`define TPC_IDX_P2_FALL   16'h60bd
`define TPC_CTRL_RST      16'h0000
`define TPC_CTRL_WMASK    16'h3737
`define TPC_CH2_BASE      8
`define TPC_B_EN          0
`define TPC_B_CONT        1
`define TPC_B_SRC         2
`define TPC_B_RISE        4
`define TPC_B_FALL        5
`define TPC_S_EN          0
`define TPC_S_RISE        1
`define TPC_S_FALL        2

`endif

//--- src/tpc_pkg.sv
// touch probe capture: shared types
// assumes tpc_cfg.svh on the include path
`include "tpc_cfg.svh"
package tpc_pkg;
    typedef struct packed {
        logic fall_en;
        logic rise_en;
        logic src_index;
        logic continuous;
        logic enable;
    } tpc_chan_cfg_t;

    typedef struct packed {
        logic fall_seen;
        logic rise_seen;
    } tpc_chan_flags_t;
endpackage

//--- src/tpc_capture.sv
// touch probe capture: two channels, control, status and four position holders
// assumes process data arrives as one-cycle index/data writes and index reads
`timescale 1ns/100ps
`default_nettype none
`include "tpc_cfg.svh"

// Functional notes
// - control bit 0 enables channel one; bit 1 picks single or continuous
// - single mode captures once per edge kind until re-armed
// - control bit 2 picks probe one input or encoder index for channel one
// - bits 4 and 5 enable rising and falling capture; bits 3,6,7 reserved
// - bit 8 enables channel two; bit 9 picks single or continuous
// - bit 10 picks probe two input or encoder index for channel two
// - bits 12 and 13 enable channel two edges; bits 11,14,15 reserved
// - status bit 0 shows channel one enable; bit 1 its rising latch
// - status bit 2 shows channel one falling edge latched
// - status bit 8 shows channel two enable; bit 9 its rising latch
// - status bit 10 shows channel two falling latch; other bits zero
// - channel one falling edge stores current position as signed 32 bits
// - channel two rising edge stores current position in its own holder
module tpc_capture
    import tpc_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // process data access
    input  wire logic        pd_wr,
    input  wire logic [15:0] pd_wr_index,
    input  wire logic [15:0] pd_wr_data,
    input  wire logic [15:0] pd_rd_index,
    output logic      [31:0] pd_rd_data,
    // probe and encoder inputs
    input  wire logic        probe1_in,
    input  wire logic        probe2_in,
    input  wire logic        enc_index,
    input  wire logic signed [31:0] pos_feedback,
    // status straight out
    output logic      [15:0] status_word
);

    logic [15:0]             ctrl_q, ctrl_d;
    logic [1:0]              s1_q, s1_d;
    logic [1:0]              s2_q, s2_d;
    logic [1:0]              si_q, si_d;
    logic [1:0]              trig_q, trig_d;
    tpc_chan_flags_t [1:0]   flg_q, flg_d;
    logic signed [31:0]      pos_q [4];
    logic signed [31:0]      pos_d [4];
    logic [15:0]             stat_d;
    logic [31:0]             rd_d;
    tpc_chan_cfg_t [1:0]     cfg;
    tpc_chan_cfg_t [1:0]     cfg_nxt;
    logic                    ctrl_wr;
    logic [1:0]              rise, fall;

    function automatic tpc_chan_cfg_t get_cfg(input logic [15:0] c, input int base);
        tpc_chan_cfg_t r;
        r.enable     = c[base + `TPC_B_EN];
        r.continuous = c[base + `TPC_B_CONT];
        r.src_index  = c[base + `TPC_B_SRC];
        r.rise_en    = c[base + `TPC_B_RISE];
        r.fall_en    = c[base + `TPC_B_FALL];
        return r;
    endfunction

    assign cfg[0]     = get_cfg(ctrl_q, 0);
    assign cfg[1]     = get_cfg(ctrl_q, `TPC_CH2_BASE);
    assign cfg_nxt[0] = get_cfg(ctrl_d, 0);
    assign cfg_nxt[1] = get_cfg(ctrl_d, `TPC_CH2_BASE);
    assign ctrl_wr    = pd_wr && (pd_wr_index == `TPC_IDX_CTRL);

    always_comb begin
        ctrl_d = ctrl_q;
        if (ctrl_wr) begin
            ctrl_d = pd_wr_data & `TPC_CTRL_WMASK;
        end
        // two-flop synchronisers; only stage two leaves the chain
        s1_d      = {s1_q[0], probe1_in};
        s2_d      = {s2_q[0], probe2_in};
        si_d      = {si_q[0], enc_index};
        trig_d[0] = cfg[0].src_index ? si_q[1] : s1_q[1];
        trig_d[1] = cfg[1].src_index ? si_q[1] : s2_q[1];
        for (int c = 0; c < 2; c++) begin
            rise[c] = trig_d[c] & ~trig_q[c];
            fall[c] = ~trig_d[c] & trig_q[c];
        end
        flg_d = flg_q;
        for (int k = 0; k < 4; k++) begin
            pos_d[k] = pos_q[k];
        end
        // control write re-arms channels that are to run in single mode
        if (ctrl_wr) begin
            for (int c = 0; c < 2; c++) begin
                if (!cfg_nxt[c].continuous) begin
                    flg_d[c] = '0;
                end
            end
        end
        // a capture in the re-arm cycle still sets its flag
        for (int c = 0; c < 2; c++) begin
            if (!cfg[c].enable || !cfg_nxt[c].enable) begin
                flg_d[c] = '0;
            end else begin
                // single mode holds after first capture of that edge
                if (rise[c] && cfg[c].rise_en &&
                    (cfg[c].continuous || !flg_d[c].rise_seen)) begin
                    flg_d[c].rise_seen = 1'b1;
                    pos_d[2*c]         = pos_feedback;
                end
                if (fall[c] && cfg[c].fall_en &&
                    (cfg[c].continuous || !flg_d[c].fall_seen)) begin
                    flg_d[c].fall_seen = 1'b1;
                    pos_d[2*c+1]       = pos_feedback;
                end
            end
        end
        stat_d = 16'h0000;
        stat_d[`TPC_S_EN]                   = cfg_nxt[0].enable;
        stat_d[`TPC_S_RISE]                 = flg_d[0].rise_seen;
        stat_d[`TPC_S_FALL]                 = flg_d[0].fall_seen;
        stat_d[`TPC_CH2_BASE + `TPC_S_EN]   = cfg_nxt[1].enable;
        stat_d[`TPC_CH2_BASE + `TPC_S_RISE] = flg_d[1].rise_seen;
        stat_d[`TPC_CH2_BASE + `TPC_S_FALL] = flg_d[1].fall_seen;
        unique case (pd_rd_index)
            `TPC_IDX_CTRL:    rd_d = {16'h0000, ctrl_q};
            `TPC_IDX_STAT:    rd_d = {16'h0000, status_word};
            `TPC_IDX_P1_RISE: rd_d = pos_q[0];
            `TPC_IDX_P1_FALL: rd_d = pos_q[1];
            `TPC_IDX_P2_RISE: rd_d = pos_q[2];
            `TPC_IDX_P2_FALL: rd_d = pos_q[3];
            default:          rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_q      <= `TPC_CTRL_RST;
            s1_q        <= 2'h0;
            s2_q        <= 2'h0;
            si_q        <= 2'h0;
            trig_q      <= 2'h0;
            flg_q       <= '0;
            status_word <= 16'h0000;
            pd_rd_data  <= 32'h0000_0000;
            for (int k = 0; k < 4; k++) begin
                pos_q[k] <= 32'h0000_0000;
            end
        end else begin
            ctrl_q      <= ctrl_d;
            s1_q        <= s1_d;
            s2_q        <= s2_d;
            si_q        <= si_d;
            trig_q      <= trig_d;
            flg_q       <= flg_d;
            status_word <= stat_d;
            pd_rd_data  <= rd_d;
            for (int k = 0; k < 4; k++) begin
                pos_q[k] <= pos_d[k];
            end
        end
    end

    // checks
    chk_disable_clears: assert property (
        @(posedge sys_clk) disable iff (rst)
        !ctrl_q[`TPC_B_EN] |=> status_word[2:1] == 2'b00)
        else $error("channel one flags survive disable");
    chk_rise_disabled: assert property (
        @(posedge sys_clk) disable iff (rst)
        !ctrl_q[`TPC_B_RISE] && !flg_q[0].rise_seen && !$past(pd_wr)
        |=> !flg_q[0].rise_seen)
        else $error("rising flag set while rising edge disabled");
    chk_fall_capture: assert property (
        @(posedge sys_clk) disable iff (rst)
        cfg[0].enable && cfg[0].fall_en && fall[0] && !flg_q[0].fall_seen && !pd_wr
        |=> pos_q[1] == $past(pos_feedback) && status_word[2])
        else $error("channel one falling capture missed");
    chk_ch2_rise: assert property (
        @(posedge sys_clk) disable iff (rst)
        cfg[1].enable && cfg[1].rise_en && rise[1] && !flg_q[1].rise_seen && !pd_wr
        |=> pos_q[2] == $past(pos_feedback) && pos_q[3] == $past(pos_q[3]))
        else $error("channel two rising capture wrong");
    chk_single_hold: assert property (
        @(posedge sys_clk) disable iff (rst)
        cfg[0].enable && !cfg[0].continuous && flg_q[0].rise_seen && !pd_wr
        |=> pos_q[0] == $past(pos_q[0]))
        else $error("single mode recaptured");
    chk_status_zero: assert property (
        @(posedge sys_clk) disable iff (rst)
        status_word[7:3] == 5'h00 && status_word[15:11] == 5'h00)
        else $error("reserved status bits set");
    chk_enable_echo: assert property (
        @(posedge sys_clk) disable iff (rst)
        pd_wr && pd_wr_index == `TPC_IDX_CTRL |=> status_word[0] == $past(pd_wr_data[0])
        && status_word[8] == $past(pd_wr_data[8]))
        else $error("status enable bits do not follow control");
    chk_src_index: assert property (
        @(posedge sys_clk) disable iff (rst)
        cfg[1].enable && cfg[1].src_index && cfg[1].rise_en && !flg_q[1].rise_seen
        && !pd_wr && $stable(ctrl_q) && $rose(si_q[1]) |=> flg_q[1].rise_seen)
        else $error("channel two index rise not latched");
    chk_ctrl_mask: assert property (
        @(posedge sys_clk) disable iff (rst)
        (ctrl_q & ~`TPC_CTRL_WMASK) == 16'h0000)
        else $error("reserved control bits stored");
    cov_ch1_fall: cover property (@(posedge sys_clk) status_word[2]);
    cov_ch2_rise: cover property (@(posedge sys_clk) status_word[9]);
    cov_ch2_fall: cover property (@(posedge sys_clk) status_word[10]);
    cov_rearm: cover property (@(posedge sys_clk) ctrl_wr && flg_q[0].rise_seen);
    cov_cont_two: cover property (@(posedge sys_clk)
        cfg[0].continuous && rise[0] && flg_q[0].rise_seen);

endmodule

`default_nettype wire

//--- sim/tpc_master.sv
// partner: fieldbus master writing and reading process data objects
// assumes the capture block samples on the rising edge of sys_clk
`timescale 1ns/100ps
`default_nettype none
module tpc_master (
    // clock
    input  wire logic        sys_clk,
    // process data
    output logic             pd_wr,
    output logic      [15:0] pd_wr_index,
    output logic      [15:0] pd_wr_data,
    output logic      [15:0] pd_rd_index,
    input  wire logic [31:0] pd_rd_data
);
    initial begin
        pd_wr = 1'b0;
        pd_wr_index = 16'h0000;
        pd_wr_data = 16'h0000;
        pd_rd_index = 16'h0000;
    end
    // one-cycle write strobe, data scrambled once released
    task automatic wr(input logic [15:0] idx, input logic [15:0] val);
        @(posedge sys_clk);
        pd_wr <= 1'b1;
        pd_wr_index <= idx;
        pd_wr_data <= val;
        @(posedge sys_clk);
        pd_wr <= 1'b0;
        pd_wr_data <= ~val;
    endtask
    // read data is registered one edge after the index
    task automatic rd(input logic [15:0] idx, output logic [31:0] val);
        @(posedge sys_clk);
        pd_rd_index <= idx;
        repeat (2) @(posedge sys_clk);
        #1 val = pd_rd_data;
    endtask
endmodule
`default_nettype wire

//--- sim/tb_top.sv
// testbench: touch probe capture driven through the master model
// assumes tpc_pkg, tpc_capture and tpc_master are compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
    import tpc_pkg::*;
    logic               sys_clk = 1'b0;
    logic               rst = 1'b1;
    logic               pd_wr;
    logic        [15:0] pd_wr_index;
    logic        [15:0] pd_wr_data;
    logic        [15:0] pd_rd_index;
    logic        [31:0] pd_rd_data;
    logic               probe1_in = 1'b0;
    logic               probe2_in = 1'b0;
    logic               enc_index = 1'b0;
    logic signed [31:0] pos = 32'h0000_0000;
    logic        [15:0] status_word;
    int                 error_cnt = 0;
    int                 checks_done = 0;

    always #10 sys_clk = ~sys_clk;

    tpc_capture uut (.sys_clk(sys_clk), .rst(rst), .pd_wr(pd_wr),
        .pd_wr_index(pd_wr_index), .pd_wr_data(pd_wr_data), .pd_rd_index(pd_rd_index),
        .pd_rd_data(pd_rd_data), .probe1_in(probe1_in), .probe2_in(probe2_in),
        .enc_index(enc_index), .pos_feedback(pos), .status_word(status_word));
    tpc_master m (.sys_clk(sys_clk), .pd_wr(pd_wr), .pd_wr_index(pd_wr_index),
        .pd_wr_data(pd_wr_data), .pd_rd_index(pd_rd_index), .pd_rd_data(pd_rd_data));

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic rc(input logic [15:0] idx, input logic [31:0] e);
        logic [31:0] v;
        m.rd(idx, v);
        `CHK(v, e)
    endtask
    // pulse selected lines {index, probe2, probe1}; pos pr on rise, pf on fall
    task automatic pulse(input logic [2:0] s, input logic [31:0] pr, input logic [31:0] pf);
        @(posedge sys_clk) pos <= pr;
        repeat (2) @(posedge sys_clk);
        {enc_index, probe2_in, probe1_in} <= s;
        repeat (6) @(posedge sys_clk);
        pos <= pf;
        repeat (2) @(posedge sys_clk);
        {enc_index, probe2_in, probe1_in} <= 3'b000;
        repeat (6) @(posedge sys_clk);
    endtask
    task automatic t_reserved;
        rc(16'h60b9, 32'h0000_0000);
        rc(16'h6000, 32'h0000_0000);
        m.wr(16'h60ba, 16'h5a5a);
        rc(16'h60ba, 32'h0000_0000);
        m.wr(16'h60b8, 16'hffff);
        rc(16'h60b8, 32'h0000_3737);
        `CHK(status_word, 16'h0101)
        m.wr(16'h60b8, 16'h0000);
        $display("test reserved done");
    endtask
    task automatic t_cont;
        m.wr(16'h60b8, 16'h0033);
        pulse(3'b001, 32'h0000_1234, 32'hffff_fff0);
        rc(16'h60ba, 32'h0000_1234);
        rc(16'h60bb, 32'hffff_fff0);
        `CHK(status_word, 16'h0007)
        pulse(3'b001, 32'h0000_0055, 32'h8000_0001);
        rc(16'h60ba, 32'h0000_0055);
        rc(16'h60bb, 32'h8000_0001);
        rc(16'h60bc, 32'h0000_0000);
        $display("test continuous done");
    endtask
    task automatic t_single;
        m.wr(16'h60b8, 16'h1515);
        pulse(3'b011, 32'h0000_0077, 32'h0000_0088);
        `CHK(status_word, 16'h0101)
        pulse(3'b100, 32'h0000_4444, 32'h0000_5555);
        rc(16'h60ba, 32'h0000_4444);
        rc(16'h60bc, 32'h0000_4444);
        `CHK(status_word, 16'h0303)
        pulse(3'b100, 32'h0000_6666, 32'h0000_7777);
        rc(16'h60ba, 32'h0000_4444);
        rc(16'h60bc, 32'h0000_4444);
        rc(16'h60bb, 32'h8000_0001);
        rc(16'h60bd, 32'h0000_0000);
        $display("test single done");
    endtask
    task automatic t_disable;
        m.wr(16'h60b8, 16'h0000);
        repeat (2) @(posedge sys_clk);
        #1 `CHK(status_word, 16'h0000)
        rc(16'h60ba, 32'h0000_4444);
        $display("test disable done");
    endtask
    task automatic t_ch2;
        m.wr(16'h60b8, 16'h3300);
        pulse(3'b011, 32'h0000_0abc, 32'hffff_8000);
        rc(16'h60bc, 32'h0000_0abc);
        rc(16'h60bd, 32'hffff_8000);
        rc(16'h60ba, 32'h0000_4444);
        `CHK(status_word, 16'h0700)
        $display("test channel two done");
    endtask

    initial begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        t_reserved;
        t_cont;
        t_single;
        t_disable;
        t_ch2;
        end_sim;
    end
    initial begin
        repeat (3000) @(posedge sys_clk);
        error_cnt++;
        end_sim;
    end
endmodule
`default_nettype wire
